/* logic/dvm_monitor_channel.v */
// Monitor output two channel: Wishbone registers, variable map, scaling
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dvm_consts.vh"

module dvm_monitor_channel (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire wb_ack_o,
    output reg [31:0] wb_dat_o,
    // Algorithm variables
    input wire [31:0] phaseATerminalVoltage,
    input wire [31:0] phaseBTerminalVoltage,
    input wire [31:0] phaseCTerminalVoltage,
    input wire [15:0] controlStateCode,
    input wire [31:0] pulseOutputRotorSpeed,
    input wire [31:0] commutationAngleSine,
    input wire [31:0] stationaryAlphaCurrent,
    input wire [31:0] stationaryBetaCurrent,
    input wire [31:0] stationaryAlphaVoltage,
    input wire [31:0] stationaryBetaVoltage,
    input wire [31:0] directAxisCurrent,
    input wire [31:0] quadratureAxisCurrent,
    input wire [31:0] directAxisVoltage,
    input wire [31:0] quadratureAxisVoltage,
    input wire [31:0] initialPositionDetectStatus,
    input wire [31:0] dcSupplyCurrentEst,
    input wire [31:0] phaseAMeasuredAmps,
    input wire [31:0] phaseBMeasuredAmps,
    input wire [31:0] phaseCMeasuredAmps,
    input wire [31:0] senseAmpGainReadback,
    input wire [31:0] voltageSenseGainReadback,
    input wire [31:0] supplyRailVoltageMeas,
    input wire [31:0] commutationAngleCosine,
    input wire [31:0] alignmentTorqueReference,
    input wire [31:0] openLoopSpeedTarget,
    input wire [31:0] openLoopTorqueReference,
    input wire [31:0] closedLoopSpeedTarget,
    input wire [31:0] closedLoopDirectReference,
    input wire [31:0] closedLoopTorqueReference,
    input wire [31:0] spinDetectStatus,
    input wire [31:0] spinDetectRotorSpeed,
    input wire [31:0] initialPositionAngle,
    input wire [31:0] backEmfDirectEst,
    input wire [31:0] backEmfQuadratureEst,
    input wire [31:0] estimatorRotorSpeed,
    input wire [31:0] estimatedRotorAngle,
    // Converter code
    output wire [`DVM_DAC_W-1:0] monitorOutputTwo
);

    // ****************************************
    // Configuration state
    // ****************************************
    reg [13:0] monitoredVariableAddress_q;
    reg outputPolaritySelect_q;
    reg [3:0] fractionalGainField_q;
    reg [3:0] enumerationShiftField_q;
    reg ack_q;
    reg [31:0] monitoredSample_q;

    wire [31:0] configWord;
    assign configWord = {9'h000, enumerationShiftField_q,
        fractionalGainField_q, outputPolaritySelect_q,
        monitoredVariableAddress_q};

    // ****************************************
    // Bus decode
    // ****************************************
    wire busReq;
    wire inRange;
    wire [13:0] busIdx;
    wire wordAligned;
    wire cfgHit;
    wire codeHit;
    wire [13:0] monIdx;

    assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
    assign busIdx = wb_adr_i[15:2];
    assign wordAligned = (wb_adr_i[1:0] == 2'h0);
    assign inRange = (wb_adr_i[31:16] == 16'h0000) & wordAligned;
    assign cfgHit = inRange & (busIdx == `DVM_IDX_MON_CONFIG);
    assign codeHit = inRange & (busIdx == `DVM_IDX_MON_CODE);
    assign monIdx = monitoredVariableAddress_q;

    // ****************************************
    // Variable map lookup
    // ****************************************
    // Two copies of one map, for the bus read path and the monitor
    // selector, so the monitored address space is the readable variable map.
    // Plain processes, so a variable change is seen while the index
    // stands still.
    reg busHit;
    reg [31:0] busData;
    reg monHit;
    reg [31:0] monData;

    always @* begin
        busHit = 1'b1;
        busData = 32'h00000000;
        if (busIdx == `DVM_IDX_PHASE_A_VOLT)
            busData = phaseATerminalVoltage;
        else if (busIdx == `DVM_IDX_PHASE_B_VOLT)
            busData = phaseBTerminalVoltage;
        else if (busIdx == `DVM_IDX_PHASE_C_VOLT)
            busData = phaseCTerminalVoltage;
        else if (busIdx == `DVM_IDX_STATE_CODE)
            busData = {16'h0000, controlStateCode};
        else if (busIdx == `DVM_IDX_PULSE_SPEED)
            busData = pulseOutputRotorSpeed;
        else if (busIdx == `DVM_IDX_ANGLE_SINE)
            busData = commutationAngleSine;
        else if (busIdx == `DVM_IDX_ALPHA_CURR)
            busData = stationaryAlphaCurrent;
        else if (busIdx == `DVM_IDX_BETA_CURR)
            busData = stationaryBetaCurrent;
        else if (busIdx == `DVM_IDX_ALPHA_VOLT)
            busData = stationaryAlphaVoltage;
        else if (busIdx == `DVM_IDX_BETA_VOLT)
            busData = stationaryBetaVoltage;
        else if (busIdx == `DVM_IDX_D_CURR)
            busData = directAxisCurrent;
        else if (busIdx == `DVM_IDX_Q_CURR)
            busData = quadratureAxisCurrent;
        else if (busIdx == `DVM_IDX_D_VOLT)
            busData = directAxisVoltage;
        else if (busIdx == `DVM_IDX_Q_VOLT)
            busData = quadratureAxisVoltage;
        else if (busIdx == `DVM_IDX_IPD_STATUS)
            busData = initialPositionDetectStatus;
        else if (busIdx == `DVM_IDX_SUPPLY_CURR)
            busData = dcSupplyCurrentEst;
        else if (busIdx == `DVM_IDX_PHASE_A_AMPS)
            busData = phaseAMeasuredAmps;
        else if (busIdx == `DVM_IDX_PHASE_B_AMPS)
            busData = phaseBMeasuredAmps;
        else if (busIdx == `DVM_IDX_PHASE_C_AMPS)
            busData = phaseCMeasuredAmps;
        else if (busIdx == `DVM_IDX_CSA_GAIN)
            busData = senseAmpGainReadback;
        else if (busIdx == `DVM_IDX_VSENSE_GAIN)
            busData = voltageSenseGainReadback;
        else if (busIdx == `DVM_IDX_SUPPLY_VOLT)
            busData = supplyRailVoltageMeas;
        else if (busIdx == `DVM_IDX_ANGLE_COSINE)
            busData = commutationAngleCosine;
        else if (busIdx == `DVM_IDX_ALIGN_TORQUE)
            busData = alignmentTorqueReference;
        else if (busIdx == `DVM_IDX_OL_SPEED)
            busData = openLoopSpeedTarget;
        else if (busIdx == `DVM_IDX_OL_TORQUE)
            busData = openLoopTorqueReference;
        else if (busIdx == `DVM_IDX_CL_SPEED)
            busData = closedLoopSpeedTarget;
        else if (busIdx == `DVM_IDX_CL_DIRECT)
            busData = closedLoopDirectReference;
        else if (busIdx == `DVM_IDX_CL_TORQUE)
            busData = closedLoopTorqueReference;
        else if (busIdx == `DVM_IDX_SPIN_STATUS)
            busData = spinDetectStatus;
        else if (busIdx == `DVM_IDX_SPIN_SPEED)
            busData = spinDetectRotorSpeed;
        else if (busIdx == `DVM_IDX_INITIAL_POSITION_ANGLE)
            busData = initialPositionAngle;
        else if (busIdx == `DVM_IDX_BEMF_D)
            busData = backEmfDirectEst;
        else if (busIdx == `DVM_IDX_BEMF_Q)
            busData = backEmfQuadratureEst;
        else if (busIdx == `DVM_IDX_EST_SPEED)
            busData = estimatorRotorSpeed;
        else if (busIdx == `DVM_IDX_EST_ANGLE)
            busData = estimatedRotorAngle;
        else
            busHit = 1'b0;
    end

    always @* begin
        monHit = 1'b1;
        monData = 32'h00000000;
        if (monIdx == `DVM_IDX_PHASE_A_VOLT)
            monData = phaseATerminalVoltage;
        else if (monIdx == `DVM_IDX_PHASE_B_VOLT)
            monData = phaseBTerminalVoltage;
        else if (monIdx == `DVM_IDX_PHASE_C_VOLT)
            monData = phaseCTerminalVoltage;
        else if (monIdx == `DVM_IDX_STATE_CODE)
            monData = {16'h0000, controlStateCode};
        else if (monIdx == `DVM_IDX_PULSE_SPEED)
            monData = pulseOutputRotorSpeed;
        else if (monIdx == `DVM_IDX_ANGLE_SINE)
            monData = commutationAngleSine;
        else if (monIdx == `DVM_IDX_ALPHA_CURR)
            monData = stationaryAlphaCurrent;
        else if (monIdx == `DVM_IDX_BETA_CURR)
            monData = stationaryBetaCurrent;
        else if (monIdx == `DVM_IDX_ALPHA_VOLT)
            monData = stationaryAlphaVoltage;
        else if (monIdx == `DVM_IDX_BETA_VOLT)
            monData = stationaryBetaVoltage;
        else if (monIdx == `DVM_IDX_D_CURR)
            monData = directAxisCurrent;
        else if (monIdx == `DVM_IDX_Q_CURR)
            monData = quadratureAxisCurrent;
        else if (monIdx == `DVM_IDX_D_VOLT)
            monData = directAxisVoltage;
        else if (monIdx == `DVM_IDX_Q_VOLT)
            monData = quadratureAxisVoltage;
        else if (monIdx == `DVM_IDX_IPD_STATUS)
            monData = initialPositionDetectStatus;
        else if (monIdx == `DVM_IDX_SUPPLY_CURR)
            monData = dcSupplyCurrentEst;
        else if (monIdx == `DVM_IDX_PHASE_A_AMPS)
            monData = phaseAMeasuredAmps;
        else if (monIdx == `DVM_IDX_PHASE_B_AMPS)
            monData = phaseBMeasuredAmps;
        else if (monIdx == `DVM_IDX_PHASE_C_AMPS)
            monData = phaseCMeasuredAmps;
        else if (monIdx == `DVM_IDX_CSA_GAIN)
            monData = senseAmpGainReadback;
        else if (monIdx == `DVM_IDX_VSENSE_GAIN)
            monData = voltageSenseGainReadback;
        else if (monIdx == `DVM_IDX_SUPPLY_VOLT)
            monData = supplyRailVoltageMeas;
        else if (monIdx == `DVM_IDX_ANGLE_COSINE)
            monData = commutationAngleCosine;
        else if (monIdx == `DVM_IDX_ALIGN_TORQUE)
            monData = alignmentTorqueReference;
        else if (monIdx == `DVM_IDX_OL_SPEED)
            monData = openLoopSpeedTarget;
        else if (monIdx == `DVM_IDX_OL_TORQUE)
            monData = openLoopTorqueReference;
        else if (monIdx == `DVM_IDX_CL_SPEED)
            monData = closedLoopSpeedTarget;
        else if (monIdx == `DVM_IDX_CL_DIRECT)
            monData = closedLoopDirectReference;
        else if (monIdx == `DVM_IDX_CL_TORQUE)
            monData = closedLoopTorqueReference;
        else if (monIdx == `DVM_IDX_SPIN_STATUS)
            monData = spinDetectStatus;
        else if (monIdx == `DVM_IDX_SPIN_SPEED)
            monData = spinDetectRotorSpeed;
        else if (monIdx == `DVM_IDX_INITIAL_POSITION_ANGLE)
            monData = initialPositionAngle;
        else if (monIdx == `DVM_IDX_BEMF_D)
            monData = backEmfDirectEst;
        else if (monIdx == `DVM_IDX_BEMF_Q)
            monData = backEmfQuadratureEst;
        else if (monIdx == `DVM_IDX_EST_SPEED)
            monData = estimatorRotorSpeed;
        else if (monIdx == `DVM_IDX_EST_ANGLE)
            monData = estimatedRotorAngle;
        else
            monHit = 1'b0;
    end

    // ****************************************
    // Acknowledge, one cycle after the request
    // ****************************************
    always @(posedge clk) begin
        if (srst)
            ack_q <= 1'b0;
        else
            ack_q <= busReq;
    end
    assign wb_ack_o = ack_q;

    // ****************************************
    // Configuration writes, byte lanes honoured
    // ****************************************
    // Writes to the variable map and to unmapped words are acknowledged
    // and dropped; the algorithm values are not ours to alter.
    always @(posedge clk) begin
        if (srst) begin
            monitoredVariableAddress_q <= `DVM_ADDR_RST;
            outputPolaritySelect_q <= `DVM_POL_RST;
            fractionalGainField_q <= `DVM_GAIN_RST;
            enumerationShiftField_q <= `DVM_SHIFT_RST;
        end else if (busReq & wb_we_i & cfgHit) begin
            if (wb_sel_i[0])
                monitoredVariableAddress_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) begin
                monitoredVariableAddress_q[13:8] <= wb_dat_i[13:8];
                outputPolaritySelect_q <= wb_dat_i[`DVM_POL_BIT];
                fractionalGainField_q[0] <= wb_dat_i[`DVM_GAIN_LSB];
            end
            if (wb_sel_i[2]) begin
                fractionalGainField_q[3:1] <= wb_dat_i[18:16];
                enumerationShiftField_q <=
                    wb_dat_i[`DVM_SHIFT_MSB:`DVM_SHIFT_LSB];
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always @(posedge clk) begin
        if (srst)
            wb_dat_o <= 32'h00000000;
        else if (busReq & ~wb_we_i) begin
            if (cfgHit)
                wb_dat_o <= configWord;
            else if (codeHit)
                wb_dat_o <= {20'h00000, monitorOutputTwo};
            else if (inRange & busHit)
                wb_dat_o <= busData;
            else
                wb_dat_o <= 32'h00000000;
        end
    end

    // ****************************************
    // Monitor sample and scaling
    // ****************************************
    // An unmapped monitor address gives a zero sample.
    always @(posedge clk) begin
        if (srst)
            monitoredSample_q <= 32'h00000000;
        else if (monHit)
            monitoredSample_q <= monData;
        else
            monitoredSample_q <= 32'h00000000;
    end

    dvm_scaler scaler (
        .clk(clk),
        .srst(srst),
        .sample(monitoredSample_q),
        .fractionalGainField(fractionalGainField_q),
        .enumerationShiftField(enumerationShiftField_q),
        .outputPolaritySelect(outputPolaritySelect_q),
        .monitorOutputTwo(monitorOutputTwo)
    );

endmodule
`default_nettype wire

/* logic/dvm_scaler.v */
// Scales one monitored sample into a registered converter code
`timescale 1ns/100ps
`default_nettype none
`include "dvm_consts.vh"

module dvm_scaler (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Sample and settings
    input wire [31:0] sample,
    input wire [3:0] fractionalGainField,
    input wire [3:0] enumerationShiftField,
    input wire outputPolaritySelect,
    // Converter code
    output reg [`DVM_DAC_W-1:0] monitorOutputTwo
);

    // ****************************************
    // Fractional path, sample is Q5.27 per unit
    // ****************************************
    wire signed [36:0] product;
    wire signed [34:0] scaled;
    wire signed [34:0] shifted;
    assign product = $signed(sample) * $signed({1'b0, fractionalGainField});
    assign scaled = {product[36], product[36:3]};
    assign shifted = scaled + `DVM_ONE_PU;

    // ****************************************
    // Enumeration path
    // ****************************************
    wire [4:0] enumValue;
    wire [19:0] enumShifted;
    assign enumValue = sample[31] ? 5'h00 :
        (|sample[30:5]) ? `DVM_ENUM_MAX : sample[4:0];
    assign enumShifted = {15'h0000, enumValue} << enumerationShiftField;

    // ****************************************
    // Output code
    // ****************************************
    reg [`DVM_DAC_W-1:0] code_d;
    always @* begin
        code_d = {`DVM_DAC_W{1'b0}};
        if (fractionalGainField == 4'h0) begin
            if (|enumShifted[19:12])
                code_d = `DVM_DAC_FULL;
            else
                code_d = enumShifted[11:0];
        end else if (outputPolaritySelect) begin
            if (scaled < 35'sh0)
                code_d = 12'h000;
            else if (scaled >= `DVM_ONE_PU)
                code_d = `DVM_DAC_FULL;
            else
                code_d = scaled[26:15];
        end else begin
            if (shifted < 35'sh0)
                code_d = 12'h000;
            else if (shifted >= `DVM_TWO_PU)
                code_d = `DVM_DAC_FULL;
            else
                code_d = shifted[27:16];
        end
    end

    always @(posedge clk) begin
        if (srst)
            monitorOutputTwo <= `DVM_CODE_RST;
        else
            monitorOutputTwo <= code_d;
    end

endmodule
`default_nettype wire

/* pkg/dvm_consts.vh */
// Constants for the monitor output two channel: map, fields, resets
`ifndef DVM_CONSTS_VH
`define DVM_CONSTS_VH

// ****************************************
// Bus geometry
// ****************************************
`define DVM_IDX_W 14
`define DVM_DAC_W 12
`define DVM_DAC_FULL 12'hfff

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define DVM_IDX_PHASE_A_VOLT 14'h017a
`define DVM_IDX_PHASE_B_VOLT 14'h017c
`define DVM_IDX_PHASE_C_VOLT 14'h017e
`define DVM_IDX_STATE_CODE 14'h0190
`define DVM_IDX_PULSE_SPEED 14'h0196
`define DVM_IDX_ANGLE_SINE 14'h01b6
`define DVM_IDX_ALPHA_CURR 14'h01d2
`define DVM_IDX_BETA_CURR 14'h01d4
`define DVM_IDX_ALPHA_VOLT 14'h01d6
`define DVM_IDX_BETA_VOLT 14'h01d8
`define DVM_IDX_D_CURR 14'h01e2
`define DVM_IDX_Q_CURR 14'h01e4
`define DVM_IDX_D_VOLT 14'h01e6
`define DVM_IDX_Q_VOLT 14'h01e8
`define DVM_IDX_MON_CONFIG 14'h00ec
`define DVM_IDX_MON_CODE 14'h00ee
`define DVM_IDX_IPD_STATUS 14'h03be
`define DVM_IDX_SUPPLY_CURR 14'h0410
`define DVM_IDX_PHASE_A_AMPS 14'h0440
`define DVM_IDX_PHASE_B_AMPS 14'h0442
`define DVM_IDX_PHASE_C_AMPS 14'h0444
`define DVM_IDX_CSA_GAIN 14'h0468
`define DVM_IDX_VSENSE_GAIN 14'h0472
`define DVM_IDX_SUPPLY_VOLT 14'h0474
`define DVM_IDX_ANGLE_COSINE 14'h04b8
`define DVM_IDX_ALIGN_TORQUE 14'h0524
`define DVM_IDX_OL_SPEED 14'h053c
`define DVM_IDX_OL_TORQUE 14'h054c
`define DVM_IDX_CL_SPEED 14'h05d2
`define DVM_IDX_CL_DIRECT 14'h0604
`define DVM_IDX_CL_TORQUE 14'h0606
`define DVM_IDX_SPIN_STATUS 14'h0680
`define DVM_IDX_SPIN_SPEED 14'h068a
`define DVM_IDX_INITIAL_POSITION_ANGLE 14'h0702
`define DVM_IDX_BEMF_D 14'h0748
`define DVM_IDX_BEMF_Q 14'h074a
`define DVM_IDX_EST_SPEED 14'h0758
`define DVM_IDX_EST_ANGLE 14'h075c

// ****************************************
// Configuration register fields
// ****************************************
`define DVM_ADDR_LSB 0
`define DVM_ADDR_MSB 13
`define DVM_POL_BIT 14
`define DVM_GAIN_LSB 15
`define DVM_GAIN_MSB 18
`define DVM_SHIFT_LSB 19
`define DVM_SHIFT_MSB 22
`define DVM_CFG_USED_MSB 22

// ****************************************
// Reset values
// ****************************************
`define DVM_ADDR_RST 14'h0000
`define DVM_POL_RST 1'h0
`define DVM_GAIN_RST 4'h8
`define DVM_SHIFT_RST 4'h0
`define DVM_CODE_RST 12'h800

// ****************************************
// Scaling constants
// ****************************************
`define DVM_ONE_PU 35'sh008000000
`define DVM_TWO_PU 35'sh010000000
`define DVM_ENUM_MAX 5'h1f

`endif

/* testbench/dvm_monitor_channel_properties.sv */
// Checker for the bus answers and converter code of the monitor channel
`timescale 1ns/100ps
`default_nettype none
module dvm_monitor_channel_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Converter code
    input wire logic [11:0] monitorOutputTwo
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ****************************************
    // Bus steps
    // ****************************************
    sequence reqTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence readDone(a);
        wb_ack_o && !wb_we_i && (wb_adr_i == a);
    endsequence

    a_ack_follows: assert property (reqTaken |=> wb_ack_o)
        else $error("no ack after a taken request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_dat_holds: assert property ($changed(wb_dat_o) |->
        $past(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o))
        else $error("read data moved without a read");
    a_cfg_reserved: assert property (
        readDone(32'h3b0) |-> wb_dat_o[31:23] == 9'h0)
        else $error("reserved config bits not zero");
    a_state_width: assert property (
        readDone(32'h640) |-> wb_dat_o[31:16] == 16'h0)
        else $error("state code wider than 16 bits");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
        (wb_adr_i[1:0] != 2'h0 || wb_adr_i[31:16] != 16'h0) |->
        wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_code_readback: assert property (readDone(32'h3b8) |->
        wb_dat_o == {20'h0, $past(monitorOutputTwo)})
        else $error("code readback differs from output");
    a_reset_vals: assert property (disable iff (1'b0)
        srst |=> !wb_ack_o && wb_dat_o == 32'h0 &&
        monitorOutputTwo == 12'h800)
        else $error("reset values wrong");
endmodule
`default_nettype wire

/* testbench/dvm_monitor_channel_tb_top.sv */
// Self-checking bench for the monitor output two channel
`timescale 1ns/100ps
`default_nettype none
module dvm_monitor_channel_tb_top;
    localparam logic [13:0] Q = 14'h1e4;
    localparam logic [31:0] ONE = 32'h08000000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    wire logic ack;
    wire logic [31:0] rdat;
    wire logic [11:0] code;
    logic [31:0] v [0:35];
    logic [13:0] mapIdx [0:36] = '{14'h17a, 14'h17c, 14'h17e, 14'h190,
        14'h196, 14'h1b6, 14'h1d2, 14'h1d4, 14'h1d6, 14'h1d8, 14'h1e2,
        14'h1e4, 14'h1e6, 14'h1e8, 14'h3be, 14'h410, 14'h440, 14'h442,
        14'h444, 14'h468, 14'h472, 14'h474, 14'h4b8, 14'h524, 14'h53c,
        14'h54c, 14'h5d2, 14'h604, 14'h606, 14'h680, 14'h68a, 14'h702,
        14'h748, 14'h74a, 14'h758, 14'h75c, 14'h000};
    logic [31:0] r;
    logic [11:0] e;
    int errTotal = 0;
    int samplesChecked = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    dvm_monitor_channel dut_u (
        .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_ack_o(ack), .wb_dat_o(rdat), .monitorOutputTwo(code),
        .phaseATerminalVoltage(v[0]), .phaseBTerminalVoltage(v[1]),
        .phaseCTerminalVoltage(v[2]), .controlStateCode(v[3][15:0]),
        .pulseOutputRotorSpeed(v[4]), .commutationAngleSine(v[5]),
        .stationaryAlphaCurrent(v[6]), .stationaryBetaCurrent(v[7]),
        .stationaryAlphaVoltage(v[8]), .stationaryBetaVoltage(v[9]),
        .directAxisCurrent(v[10]), .quadratureAxisCurrent(v[11]),
        .directAxisVoltage(v[12]), .quadratureAxisVoltage(v[13]),
        .initialPositionDetectStatus(v[14]), .dcSupplyCurrentEst(v[15]),
        .phaseAMeasuredAmps(v[16]), .phaseBMeasuredAmps(v[17]),
        .phaseCMeasuredAmps(v[18]), .senseAmpGainReadback(v[19]),
        .voltageSenseGainReadback(v[20]), .supplyRailVoltageMeas(v[21]),
        .commutationAngleCosine(v[22]), .alignmentTorqueReference(v[23]),
        .openLoopSpeedTarget(v[24]), .openLoopTorqueReference(v[25]),
        .closedLoopSpeedTarget(v[26]), .closedLoopDirectReference(v[27]),
        .closedLoopTorqueReference(v[28]), .spinDetectStatus(v[29]),
        .spinDetectRotorSpeed(v[30]), .initialPositionAngle(v[31]),
        .backEmfDirectEst(v[32]), .backEmfQuadratureEst(v[33]),
        .estimatorRotorSpeed(v[34]), .estimatedRotorAngle(v[35])
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic conclude;
        if (errTotal == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // A missing ack is caught by the run's cycle ceiling
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    // Set one sample, configure the channel, then check the code
    task automatic run(input logic [13:0] ix, input logic [31:0] s,
                       input logic p, input logic [3:0] g,
                       input logic [3:0] sh, input logic [11:0] exp);
        @(posedge clk);
        v[ix == 14'h190 ? 3 : 11] <= s;
        bus(1'b1, 32'h3b0, {9'h0, sh, g, p, ix});
        repeat (3) @(posedge clk);
        chk({20'h0, code}, {20'h0, exp});
        rd(32'h3b8, {20'h0, exp});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errTotal++;
            $display("wrong value at %0t: run timed out", $time);
            conclude;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 36; i++)
            v[i] = {i[7:0], 8'ha5, i[7:0] ^ 8'h3c, 8'h96};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(32'h3b0, 32'h00040000);
        rd(32'h3b8, 32'h00000800);
        for (int i = 0; i < 36; i++) begin
            rd({16'h0, mapIdx[i], 2'b00},
               i == 3 ? {16'h0, v[3][15:0]} : v[i]);
        end
        bus(1'b1, 32'h640, 32'hffffffff);
        rd(32'h640, {16'h0, v[3][15:0]});
        rd(32'h4, 32'h0);
        rd(32'h642, 32'h0);
        rd(32'h10000640, 32'h0);
        bus(1'b1, 32'h3b0, 32'hffffffff);
        rd(32'h3b0, 32'h007fffff);
        sel <= 4'h1;
        bus(1'b1, 32'h3b0, 32'h0);
        sel <= 4'hf;
        rd(32'h3b0, 32'h007fff00);
        for (int g = 1; g < 16; g++) begin
            e = g < 8 ? 12'(g * 512) : 12'hfff;
            run(Q, ONE, 1'b1, g[3:0], 4'h0, e);
            e = g < 8 ? 12'(2048 + g * 256) : 12'hfff;
            run(Q, ONE, 1'b0, g[3:0], 4'h0, e);
        end
        run(Q, 32'hf8000000, 1'b0, 4'h8, 4'h0, 12'h000);
        run(Q, 32'h0, 1'b0, 4'h8, 4'h0, 12'h800);
        run(Q, 32'h0, 1'b1, 4'h8, 4'h0, 12'h000);
        for (int sh = 0; sh < 16; sh++) begin
            e = sh < 12 ? 12'(1 << sh) : 12'hfff;
            run(Q, 32'h1, 1'b0, 4'h0, sh[3:0], e);
        end
        run(Q, 32'h04000000, 1'b1, 4'h8, 4'hf, 12'h800);
        run(Q, 32'd100, 1'b1, 4'h0, 4'h0, 12'h01f);
        run(Q, 32'hffffffff, 1'b1, 4'h0, 4'h2, 12'h000);
        run(14'h190, 32'h0000000e, 1'b0, 4'h0, 4'h0, 12'h00e);
        run(14'h190, 32'h00000018, 1'b0, 4'h0, 4'h0, 12'h018);
        run(14'h0001, 32'h0, 1'b0, 4'h8, 4'h0, 12'h800);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({20'h0, code}, 32'h800);
        rd(32'h3b0, 32'h00040000);
        conclude;
    end
endmodule

bind dvm_monitor_channel dvm_monitor_channel_properties chk_u (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .monitorOutputTwo(monitorOutputTwo)
);
`default_nettype wire
